// *** src/mip_params.svh ***
`ifndef MIP_PARAMS_SVH
`define MIP_PARAMS_SVH

// Slave address: fixed upper four bits, pins give the low three
`define MIP_ADDR_HIGH          4'h5
// Register offsets
`define MIP_OFS_HYST_LIMIT     8'h3b
`define MIP_OFS_FAN1_LIMIT     8'h3c
`define MIP_OFS_FAN2_LIMIT     8'h3d
`define MIP_OFS_MAKER_ID       8'h3e
// Reset values
`define MIP_RST_HYST_LIMIT     8'h4b
`define MIP_RST_FAN1_LIMIT     8'hff
`define MIP_RST_FAN2_LIMIT     8'hff
// Arbitrary neutral identity value
`define MIP_MAKER_ID_DEFAULT   8'h5a
// Value read back from offsets outside this block
`define MIP_UNMAPPED_READ      8'h00
// Bytes after the address: pointer and one data byte
`define MIP_MAX_WRITE_BYTES    2
// Timing: bus clock period and system clock period in ns
`define MIP_SCL_PERIOD_NS      10000
`define MIP_MCLK_PERIOD_NS     10
`define MIP_QUARTER_CYCLES     ((`MIP_SCL_PERIOD_NS) / 4 / (`MIP_MCLK_PERIOD_NS))

`endif

// *** src/mip_pkg.sv ***
package mip_pkg;

  typedef enum logic [1:0] {
    MIP_CMD_WRITE_PTR,
    MIP_CMD_WRITE_REG,
    MIP_CMD_READ
  } mip_cmd_type;

  typedef enum {
    MIP_D_IDLE,
    MIP_D_ADDR,
    MIP_D_ADDR_ACK,
    MIP_D_RX,
    MIP_D_RX_ACK,
    MIP_D_TX,
    MIP_D_TX_ACK,
    MIP_D_IGNORE
  } mip_dev_state_type;

  typedef enum {
    MIP_H_IDLE,
    MIP_H_START,
    MIP_H_BIT,
    MIP_H_STOP
  } mip_host_state_type;

endpackage : mip_pkg

// *** src/mip_bus_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface mip_bus_if;
  logic scl_o;
  logic scl_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl;
  logic sda;

  // ---------------------------------------------------------------
  // Open-drain wires with pull-ups
  // ---------------------------------------------------------------
  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = (sda_host_oe ? sda_host_o : 1'b1) & (sda_dev_oe ? sda_dev_o : 1'b1);

  modport host (
    output scl_o,
    output scl_oe,
    output sda_host_o,
    output sda_host_oe,
    input  sda
  );

  modport dev (
    input  scl,
    input  sda,
    output sda_dev_o,
    output sda_dev_oe
  );
endinterface : mip_bus_if

`default_nettype wire

// *** src/mip_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mip_params.svh"

module mip_host #(
  parameter int QUARTER_DIV = `MIP_QUARTER_CYCLES
) (
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  mip_bus_if.host                    bus,
  input  wire logic                  cmd_valid,
  output logic                       cmd_ready,
  input  wire mip_pkg::mip_cmd_type  cmd_kind,
  input  wire logic [6:0]            cmd_slave_addr,
  input  wire logic [7:0]            cmd_ptr,
  input  wire logic [7:0]            cmd_data,
  output logic                       done,
  output logic                       nack,
  output logic [7:0]                 rd_data
);

  if (QUARTER_DIV < 2) begin : g_bad_div
    $error("QUARTER_DIV must be at least 2");
  end

  mip_pkg::mip_host_state_type state_reg;
  mip_pkg::mip_cmd_type        kind_reg;
  logic [15:0] div_reg;
  logic        tick;
  logic [1:0]  q_reg;
  logic [3:0]  bit_reg;
  logic [1:0]  byte_reg;
  logic [6:0]  addr_reg;
  logic [7:0]  ptr_reg;
  logic [7:0]  data_reg;
  logic [7:0]  tx_reg;
  logic [7:0]  rx_reg;
  logic        ack_fail_reg;
  logic        scl_oe_reg;
  logic        sda_oe_reg;
  logic        done_reg;
  logic        nack_reg;
  logic [7:0]  rd_data_reg;
  logic        sda_meta_reg;
  logic        sda_sync_reg;
  logic        rx_byte;
  logic [1:0]  last_byte;

  // Bytes after the address byte for each command
  function automatic logic [1:0] last_of(input mip_pkg::mip_cmd_type k);
    last_of = (k == mip_pkg::MIP_CMD_WRITE_REG) ? 2'd2 : 2'd1;  // [R14] [R17]
  endfunction : last_of

  function automatic logic [7:0] byte_of(input logic [1:0] idx);
    case (idx)
      2'd1:    byte_of = ptr_reg;
      2'd2:    byte_of = data_reg;
      default: byte_of = {addr_reg, (kind_reg == mip_pkg::MIP_CMD_READ)};  // [R8] [R13]
    endcase
  endfunction : byte_of

  assign cmd_ready       = (state_reg == mip_pkg::MIP_H_IDLE);
  assign tick            = (div_reg == 16'(QUARTER_DIV - 1));
  assign rx_byte         = (kind_reg == mip_pkg::MIP_CMD_READ) && (byte_reg == 2'd1);
  assign last_byte       = last_of(kind_reg);
  assign bus.scl_o       = 1'b0;
  assign bus.scl_oe      = scl_oe_reg;
  assign bus.sda_host_o  = 1'b0;
  assign bus.sda_host_oe = sda_oe_reg;
  assign done            = done_reg;
  assign nack            = nack_reg;
  assign rd_data         = rd_data_reg;

  // ---------------------------------------------------------------
  // Data line synchroniser and quarter-bit divider
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
    end else begin
      sda_meta_reg <= bus.sda;
      sda_sync_reg <= sda_meta_reg;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      div_reg <= 16'h0000;
    end else if (cmd_ready || tick) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Frame sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg    <= mip_pkg::MIP_H_IDLE;
      kind_reg     <= mip_pkg::MIP_CMD_WRITE_PTR;
      q_reg        <= 2'd0;
      bit_reg      <= 4'd0;
      byte_reg     <= 2'd0;
      addr_reg     <= 7'h00;
      ptr_reg      <= 8'h00;
      data_reg     <= 8'h00;
      tx_reg       <= 8'h00;
      rx_reg       <= 8'h00;
      ack_fail_reg <= 1'b0;
      scl_oe_reg   <= 1'b0;
      sda_oe_reg   <= 1'b0;
      done_reg     <= 1'b0;
      nack_reg     <= 1'b0;
      rd_data_reg  <= 8'h00;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        mip_pkg::MIP_H_IDLE: begin
          if (cmd_valid) begin
            kind_reg  <= cmd_kind;
            addr_reg  <= cmd_slave_addr;
            ptr_reg   <= cmd_ptr;
            data_reg  <= cmd_data;
            nack_reg  <= 1'b0;
            q_reg     <= 2'd0;
            state_reg <= mip_pkg::MIP_H_START;
          end
        end
        mip_pkg::MIP_H_START: begin
          if (tick) begin
            q_reg <= q_reg + 2'd1;
            if (q_reg == 2'd1) begin
              sda_oe_reg <= 1'b1;  // [R4]
            end
            if (q_reg == 2'd2) begin
              scl_oe_reg <= 1'b1;
            end
            if (q_reg == 2'd3) begin
              bit_reg   <= 4'd0;
              byte_reg  <= 2'd0;
              tx_reg    <= byte_of(2'd0);
              state_reg <= mip_pkg::MIP_H_BIT;
            end
          end
        end
        mip_pkg::MIP_H_BIT: begin
          if (tick) begin
            q_reg <= q_reg + 2'd1;
            case (q_reg)
              2'd0: sda_oe_reg <= (bit_reg != 4'd8) && !rx_byte && !tx_reg[7];  // [R10] [R12]
              2'd1: scl_oe_reg <= 1'b0;
              2'd2: begin
                if (bit_reg != 4'd8) begin
                  rx_reg <= {rx_reg[6:0], sda_sync_reg};
                  tx_reg <= {tx_reg[6:0], 1'b0};
                end
                ack_fail_reg <= sda_sync_reg && !rx_byte;
              end
              default: begin
                scl_oe_reg <= 1'b1;
                if (bit_reg == 4'd8) begin  // [R9]
                  if (rx_byte) begin
                    rd_data_reg <= rx_reg;
                  end
                  if (ack_fail_reg) begin
                    nack_reg <= 1'b1;
                  end
                  if (ack_fail_reg || byte_reg == last_byte) begin
                    state_reg <= mip_pkg::MIP_H_STOP;  // [R11] [R12]
                  end else begin
                    byte_reg <= byte_reg + 2'd1;
                    tx_reg   <= byte_of(byte_reg + 2'd1);
                    bit_reg  <= 4'd0;
                  end
                end else begin
                  bit_reg <= bit_reg + 4'd1;
                end
              end
            endcase
          end
        end
        mip_pkg::MIP_H_STOP: begin
          if (tick) begin
            q_reg <= q_reg + 2'd1;
            case (q_reg)
              2'd0: sda_oe_reg <= 1'b1;
              2'd1: scl_oe_reg <= 1'b0;
              2'd2: sda_oe_reg <= 1'b0;  // [R10]
              default: begin
                done_reg  <= 1'b1;
                state_reg <= mip_pkg::MIP_H_IDLE;
              end
            endcase
          end
        end
        default: state_reg <= mip_pkg::MIP_H_IDLE;
      endcase
    end
  end

endmodule : mip_host

`default_nettype wire

// *** src/mip_dev.sv ***
// What this block does
// (R1) Slave address upper bits fixed 0101
// (R2) Pins 000..111 give addresses 0x28..0x2F
// (R3) Address pins sampled continuously
// (R4) START: data falls while clock high
// (R5) Shift in address then direction, MSB first
// (R6) Matching address acknowledged before ninth pulse
// (R7) Other address: stay idle, data released
// (R8) Direction 0 writes, 1 reads
// (R9) Nine pulses per byte, acknowledge last
// (R10) Data stable while clock high; rise is STOP
// (R11) Master ends write with STOP
// (R12) Master ends read with NACK then STOP
// (R13) One direction per transfer
// (R14) Writes carry one or two bytes; reads one
// (R15) First written byte loads the pointer
// (R16) Second written byte goes to pointed register
// (R17) Pointer-only write then separate read
// (R18) Read returns register at pointer
// (R19) Hysteresis limit at 0x3B, resets 0x4B
// (R20) Fan limits at 0x3C, 0x3D, reset 0xFF
// (R21) STOP or new START abandons current byte
`timescale 1ns/1ps
`default_nettype none
`include "mip_params.svh"

module mip_dev #(
  parameter logic [7:0] MAKER_ID = `MIP_MAKER_ID_DEFAULT  // Arbitrary value
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        link_clk,
  mip_bus_if.dev           bus,
  input  wire logic        addr_select_bit0,
  input  wire logic        addr_select_bit1,
  input  wire logic        addr_select_bit2,
  output logic [7:0]       overtemp_hysteresis_limit,
  output logic [7:0]       fan1_count_limit,
  output logic [7:0]       fan2_count_limit
);

  mip_pkg::mip_dev_state_type state_reg;
  logic [1:0] rst_sync_reg;
  logic       link_rst;
  logic       scl_meta_reg;
  logic       scl_sync_reg;
  logic       scl_prev_reg;
  logic       sda_meta_reg;
  logic       sda_sync_reg;
  logic       sda_prev_reg;
  logic [2:0] pins_meta_reg;
  logic [2:0] pins_sync_reg;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic [6:0] own_addr;
  logic       byte_end;
  logic [3:0] bit_cnt_reg;
  logic [1:0] byte_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic       rw_reg;
  logic       sda_oe_reg;
  logic [7:0] ptr_reg;
  logic [7:0] wr_data_reg;
  logic       wr_tgl_reg;
  logic       rd_tgl_reg;
  logic [2:0] rd_ack_sync_reg;
  logic [7:0] rd_hold_reg;
  logic [2:0] wr_sync_reg;
  logic [2:0] rd_sync_reg;
  logic [7:0] rd_data_reg;
  logic       rd_ack_tgl_reg;
  logic [7:0] hyst_reg;
  logic [7:0] fan1_reg;
  logic [7:0] fan2_reg;

  // ---------------------------------------------------------------
  // Link-side reset and pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_sync_reg <= 2'b11;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b0};
    end
  end
  assign link_rst = rst_sync_reg[1];

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      scl_meta_reg  <= 1'b1;
      scl_sync_reg  <= 1'b1;
      scl_prev_reg  <= 1'b1;
      sda_meta_reg  <= 1'b1;
      sda_sync_reg  <= 1'b1;
      sda_prev_reg  <= 1'b1;
      pins_meta_reg <= 3'h0;
      pins_sync_reg <= 3'h0;
    end else begin
      scl_meta_reg  <= bus.scl;
      scl_sync_reg  <= scl_meta_reg;
      scl_prev_reg  <= scl_sync_reg;
      sda_meta_reg  <= bus.sda;
      sda_sync_reg  <= sda_meta_reg;
      sda_prev_reg  <= sda_sync_reg;
      pins_meta_reg <= {addr_select_bit2, addr_select_bit1, addr_select_bit0};  // [R3]
      pins_sync_reg <= pins_meta_reg;
    end
  end

  assign scl_rise   = scl_sync_reg && !scl_prev_reg;
  assign scl_fall   = !scl_sync_reg && scl_prev_reg;
  assign start_seen = scl_sync_reg && scl_prev_reg && sda_prev_reg && !sda_sync_reg;  // [R4]
  assign stop_seen  = scl_sync_reg && scl_prev_reg && !sda_prev_reg && sda_sync_reg;  // [R10]
  assign own_addr   = {`MIP_ADDR_HIGH, pins_sync_reg};  // [R1] [R2]
  assign byte_end   = scl_fall && (bit_cnt_reg == 4'd8) && !start_seen && !stop_seen;

  assign bus.sda_dev_o  = 1'b0;
  assign bus.sda_dev_oe = sda_oe_reg;

  // ---------------------------------------------------------------
  // Link-side byte engine
  // ---------------------------------------------------------------
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      state_reg    <= mip_pkg::MIP_D_IDLE;
      bit_cnt_reg  <= 4'd0;
      byte_cnt_reg <= 2'd0;
      shift_reg    <= 8'h00;
      tx_reg       <= 8'h00;
      rw_reg       <= 1'b0;
      sda_oe_reg   <= 1'b0;
    end else if (start_seen) begin
      state_reg    <= mip_pkg::MIP_D_ADDR;  // [R4] [R21]
      bit_cnt_reg  <= 4'd0;
      byte_cnt_reg <= 2'd0;
      sda_oe_reg   <= 1'b0;
    end else if (stop_seen) begin
      state_reg  <= mip_pkg::MIP_D_IDLE;  // [R10] [R21]
      sda_oe_reg <= 1'b0;
    end else begin
      case (state_reg)
        mip_pkg::MIP_D_ADDR, mip_pkg::MIP_D_RX: begin
          if (scl_rise && bit_cnt_reg != 4'd8) begin
            shift_reg   <= {shift_reg[6:0], sda_sync_reg};  // [R5]
            bit_cnt_reg <= bit_cnt_reg + 4'd1;
          end
          if (byte_end) begin
            bit_cnt_reg <= 4'd0;
            if (state_reg == mip_pkg::MIP_D_ADDR) begin
              if (shift_reg[7:1] == own_addr) begin
                rw_reg     <= shift_reg[0];  // [R8] [R13]
                sda_oe_reg <= 1'b1;  // [R6]
                state_reg  <= mip_pkg::MIP_D_ADDR_ACK;
              end else begin
                state_reg <= mip_pkg::MIP_D_IGNORE;  // [R7]
              end
            end else if (byte_cnt_reg < 2'(`MIP_MAX_WRITE_BYTES)) begin
              sda_oe_reg <= 1'b1;  // [R9]
              state_reg  <= mip_pkg::MIP_D_RX_ACK;
            end else begin
              state_reg <= mip_pkg::MIP_D_IGNORE;  // [R14]
            end
          end
        end
        mip_pkg::MIP_D_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_reg) begin
              tx_reg     <= rd_hold_reg;  // [R18]
              sda_oe_reg <= !rd_hold_reg[7];
              state_reg  <= mip_pkg::MIP_D_TX;
            end else begin
              sda_oe_reg <= 1'b0;
              state_reg  <= mip_pkg::MIP_D_RX;
            end
          end
        end
        mip_pkg::MIP_D_RX_ACK: begin
          if (scl_fall) begin
            sda_oe_reg   <= 1'b0;
            byte_cnt_reg <= byte_cnt_reg + 2'd1;
            state_reg    <= mip_pkg::MIP_D_RX;
          end
        end
        mip_pkg::MIP_D_TX: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'd1;
          end
          if (scl_fall) begin
            if (bit_cnt_reg == 4'd8) begin
              sda_oe_reg <= 1'b0;
              state_reg  <= mip_pkg::MIP_D_TX_ACK;
            end else begin
              tx_reg     <= {tx_reg[6:0], 1'b0};
              sda_oe_reg <= !tx_reg[6];  // [R10]
            end
          end
        end
        mip_pkg::MIP_D_TX_ACK: begin
          if (scl_rise) begin
            state_reg <= mip_pkg::MIP_D_IGNORE;  // [R12] [R14]
          end
        end
        default: sda_oe_reg <= 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pointer, write and read requests toward the register side
  // ---------------------------------------------------------------
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      ptr_reg     <= 8'h00;
      wr_data_reg <= 8'h00;
      wr_tgl_reg  <= 1'b0;
    end else if (state_reg == mip_pkg::MIP_D_RX && byte_end) begin
      if (byte_cnt_reg == 2'd0) begin
        ptr_reg <= shift_reg;  // [R15] [R17]
      end else if (byte_cnt_reg == 2'd1) begin
        wr_data_reg <= shift_reg;  // [R16]
        wr_tgl_reg  <= !wr_tgl_reg;
      end
    end
  end

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      rd_tgl_reg <= 1'b0;
    end else if (state_reg == mip_pkg::MIP_D_ADDR && byte_end &&
                 shift_reg[7:1] == own_addr && shift_reg[0]) begin
      rd_tgl_reg <= !rd_tgl_reg;  // [R18]
    end
  end

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      rd_ack_sync_reg <= 3'h0;
      rd_hold_reg     <= 8'h00;
    end else begin
      rd_ack_sync_reg <= {rd_ack_sync_reg[1:0], rd_ack_tgl_reg};
      if (rd_ack_sync_reg[2] != rd_ack_sync_reg[1]) begin
        rd_hold_reg <= rd_data_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // Register side
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_sync_reg <= 3'h0;
      rd_sync_reg <= 3'h0;
    end else begin
      wr_sync_reg <= {wr_sync_reg[1:0], wr_tgl_reg};
      rd_sync_reg <= {rd_sync_reg[1:0], rd_tgl_reg};
    end
  end

  // Pointer and write data are stable long before their toggle arrives
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hyst_reg <= `MIP_RST_HYST_LIMIT;  // [R19]
      fan1_reg <= `MIP_RST_FAN1_LIMIT;  // [R20]
      fan2_reg <= `MIP_RST_FAN2_LIMIT;
    end else if (wr_sync_reg[2] != wr_sync_reg[1]) begin
      case (ptr_reg)
        `MIP_OFS_HYST_LIMIT: hyst_reg <= wr_data_reg;  // [R16] [R19]
        `MIP_OFS_FAN1_LIMIT: fan1_reg <= wr_data_reg;  // [R20]
        `MIP_OFS_FAN2_LIMIT: fan2_reg <= wr_data_reg;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_reg    <= 8'h00;
      rd_ack_tgl_reg <= 1'b0;
    end else if (rd_sync_reg[2] != rd_sync_reg[1]) begin
      rd_ack_tgl_reg <= !rd_ack_tgl_reg;
      case (ptr_reg)
        `MIP_OFS_HYST_LIMIT: rd_data_reg <= hyst_reg;  // [R18] [R19]
        `MIP_OFS_FAN1_LIMIT: rd_data_reg <= fan1_reg;  // [R20]
        `MIP_OFS_FAN2_LIMIT: rd_data_reg <= fan2_reg;
        `MIP_OFS_MAKER_ID:   rd_data_reg <= MAKER_ID;
        default:             rd_data_reg <= `MIP_UNMAPPED_READ;
      endcase
    end
  end

  assign overtemp_hysteresis_limit = hyst_reg;
  assign fan1_count_limit          = fan1_reg;
  assign fan2_count_limit          = fan2_reg;

endmodule : mip_dev

`default_nettype wire

// *** test/mip_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none

module mip_monitor #(
  parameter int QUARTER_DIV = 20
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_host_oe,
  input wire logic sda_dev_oe
);
  localparam int START_GAP = QUARTER_DIV + 8;
  logic       scl_q_reg;
  logic       sda_q_reg;
  logic [4:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic       rd_reg;
  logic       stop_ev;
  logic       rise_ev;

  // ---------------------------------------------------------------
  // Frame tracking on the wire
  // ---------------------------------------------------------------
  assign stop_ev = scl && scl_q_reg && !sda_q_reg && sda;
  assign rise_ev = scl && !scl_q_reg;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      scl_q_reg <= scl;
      sda_q_reg <= sda;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_cnt_reg <= 5'h00;
    end else if (scl && scl_q_reg && sda_q_reg && !sda) begin
      bit_cnt_reg <= 5'h00;
    end else if (rise_ev && bit_cnt_reg != 5'h1f) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_reg <= 8'h00;
      rd_reg    <= 1'b0;
    end else if (rise_ev) begin
      shift_reg <= {shift_reg[6:0], sda};
      if (bit_cnt_reg == 5'h07) rd_reg <= sda;
    end
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking mon_cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  AST_DEV_SET_SCL_LOW: assert property ($rose(sda_dev_oe) |-> !scl)
    else $error("device pulled data while clock high");
  AST_DEV_FREE_SCL_LOW: assert property ($fell(sda_dev_oe) |-> !scl)
    else $error("device released data while clock high");
  AST_DEV_DRIVE_HOLD: assert property ($rose(sda_dev_oe) |-> sda_dev_oe [*8])
    else $error("device drive too short");
  AST_ADDR_QUIET: assert property (sda_dev_oe |-> bit_cnt_reg >= 5'h08)
    else $error("device drove during address byte");
  AST_ACK_OWN_ADDR: assert property (
    $rose(sda_dev_oe) && bit_cnt_reg == 5'h08 |-> shift_reg[7:4] == 4'h5)
    else $error("ack for foreign address");
  AST_WRITE_ACK_ONLY: assert property (
    sda_dev_oe && !rd_reg |-> bit_cnt_reg inside {5'h08, 5'h09, 5'h11, 5'h12, 5'h1a, 5'h1b})
    else $error("device drove outside write ack slots");
  AST_READ_SPAN: assert property (
    sda_dev_oe && rd_reg |-> bit_cnt_reg inside {[5'h08:5'h11]})
    else $error("device drove outside read byte");
  AST_STOP_IDLE: assert property (stop_ev |-> ##1 !sda_dev_oe [*8])
    else $error("device drove after stop");
  AST_START_TO_CLOCK: assert property (
    $fell(sda) && scl && sda_host_oe |-> ##[1:START_GAP] !scl)
    else $error("no clock after start");
  AST_SCL_HIGH_SPAN: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high too short");

  cover property (rd_reg && $fell(sda_dev_oe) && bit_cnt_reg == 5'h11);
  cover property (!rd_reg && $rose(sda_dev_oe) && bit_cnt_reg == 5'h11);
  cover property (stop_ev);
endmodule : mip_monitor

`default_nettype wire

// *** test/monitor_i2c_register_port_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mip_params.svh"

module monitor_i2c_register_port_tb_top;
  localparam int QDIV = 20;
  logic                 mclk;
  logic                 link_clk;
  logic                 sys_rst;
  logic                 cmd_valid;
  logic                 cmd_ready;
  mip_pkg::mip_cmd_type cmd_kind;
  logic [6:0]           cmd_slave_addr;
  logic [7:0]           cmd_ptr;
  logic [7:0]           cmd_data;
  logic                 done;
  logic                 nack;
  logic [7:0]           rd_data;
  logic [2:0]           pins;
  logic [7:0]           hyst_lim;
  logic [7:0]           fan1_lim;
  logic [7:0]           fan2_lim;
  int                   mismatches;
  int                   tests_run;

  // ---------------------------------------------------------------
  // Both ends on one bus
  // ---------------------------------------------------------------
  mip_bus_if bus_if ();

  mip_host #(.QUARTER_DIV(QDIV)) mip_host_inst (
    .mclk(mclk), .sys_rst(sys_rst), .bus(bus_if.host), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_slave_addr(cmd_slave_addr),
    .cmd_ptr(cmd_ptr), .cmd_data(cmd_data), .done(done), .nack(nack), .rd_data(rd_data)
  );

  mip_dev mip_dev_inst (
    .mclk(mclk), .sys_rst(sys_rst), .link_clk(link_clk), .bus(bus_if.dev),
    .addr_select_bit0(pins[0]), .addr_select_bit1(pins[1]), .addr_select_bit2(pins[2]),
    .overtemp_hysteresis_limit(hyst_lim), .fan1_count_limit(fan1_lim),
    .fan2_count_limit(fan2_lim)
  );

  mip_monitor #(.QUARTER_DIV(QDIV)) mip_monitor_inst (
    .mclk(mclk), .sys_rst(sys_rst), .scl(bus_if.scl), .sda(bus_if.sda),
    .sda_host_oe(bus_if.sda_host_oe), .sda_dev_oe(bus_if.sda_dev_oe)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    link_clk = 1'b0;
    #3;
    forever #16 link_clk = ~link_clk;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  // One command, presented for one cycle once ready, then wait for its done pulse
  task automatic run_cmd(input mip_pkg::mip_cmd_type kind, input logic [6:0] addr,
                         input logic [7:0] ptr, input logic [7:0] data);
    int n;
    while (cmd_ready !== 1'b1) @(negedge mclk);
    @(posedge mclk);
    cmd_kind       <= kind;
    cmd_slave_addr <= addr;
    cmd_ptr        <= ptr;
    cmd_data       <= data;
    cmd_valid      <= 1'b1;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    for (n = 0; n < 5000 && done !== 1'b1; n++) @(negedge mclk);
    check({7'h00, done}, 8'h01);
    @(posedge mclk);
  endtask : run_cmd

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_values;
    check(hyst_lim, `MIP_RST_HYST_LIMIT);
    check(fan1_lim, `MIP_RST_FAN1_LIMIT);
    check(fan2_lim, `MIP_RST_FAN2_LIMIT);
  endtask : t_reset_values

  task automatic t_addr_pins;
    for (int i = 0; i < 8; i++) begin
      pins <= i[2:0];
      run_cmd(mip_pkg::MIP_CMD_WRITE_PTR, {4'h5, i[2:0]}, 8'h3b, 8'h00);
      check({7'h00, nack}, 8'h00);
      run_cmd(mip_pkg::MIP_CMD_WRITE_PTR, {4'h5, i[2:0] + 3'h1}, 8'h3b, 8'h00);
      check({7'h00, nack}, 8'h01);
    end
    run_cmd(mip_pkg::MIP_CMD_WRITE_PTR, {4'hd, pins}, 8'h3b, 8'h00);
    check({7'h00, nack}, 8'h01);
  endtask : t_addr_pins

  task automatic t_write_read;
    pins <= 3'h5;
    run_cmd(mip_pkg::MIP_CMD_WRITE_REG, 7'h2d, 8'h3b, 8'ha5);
    run_cmd(mip_pkg::MIP_CMD_WRITE_REG, 7'h2d, 8'h3c, 8'h12);
    run_cmd(mip_pkg::MIP_CMD_WRITE_REG, 7'h2d, 8'h3d, 8'h5c);
    check(hyst_lim, 8'ha5);
    check(fan1_lim, 8'h12);
    check(fan2_lim, 8'h5c);
    run_cmd(mip_pkg::MIP_CMD_READ, 7'h2d, 8'h00, 8'h00);
    check(rd_data, 8'h5c);
    run_cmd(mip_pkg::MIP_CMD_WRITE_PTR, 7'h2d, 8'h3b, 8'h00);
    run_cmd(mip_pkg::MIP_CMD_READ, 7'h2d, 8'h00, 8'h00);
    check(rd_data, 8'ha5);
    run_cmd(mip_pkg::MIP_CMD_READ, 7'h2d, 8'h00, 8'h00);
    check(rd_data, 8'ha5);
    run_cmd(mip_pkg::MIP_CMD_WRITE_REG, 7'h2d, 8'h3e, 8'h00);
    run_cmd(mip_pkg::MIP_CMD_READ, 7'h2d, 8'h00, 8'h00);
    check(rd_data, `MIP_MAKER_ID_DEFAULT);
    run_cmd(mip_pkg::MIP_CMD_WRITE_PTR, 7'h2d, 8'h50, 8'h00);
    run_cmd(mip_pkg::MIP_CMD_READ, 7'h2d, 8'h00, 8'h00);
    check(rd_data, `MIP_UNMAPPED_READ);
  endtask : t_write_read

  initial begin
    mismatches     = 0;
    tests_run      = 0;
    sys_rst        = 1'b1;
    cmd_valid      = 1'b0;
    cmd_kind       = mip_pkg::MIP_CMD_WRITE_PTR;
    cmd_slave_addr = 7'h00;
    cmd_ptr        = 8'h00;
    cmd_data       = 8'h00;
    pins           = 3'h0;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (20) @(posedge mclk);
    t_reset_values;
    t_addr_pins;
    t_write_read;
    wrap_up;
  end

  initial begin
    repeat (90000) @(posedge mclk);
    mismatches = mismatches + 1;
    wrap_up;
  end
endmodule : monitor_i2c_register_port_tb_top

`default_nettype wire
